// ===== src/scerr_top.sv
// Scale error supervisor: classifies per-scale weighing faults into codes.
// Assumes fault inputs come from pins (synchronised here) and that weight
// comparisons against limits arrive as flags from the weighing datapath.
module scerr_top
  #(
    parameter int NSCALE = scerr_pkg::SCERR_NSCALE,
    parameter int SETTLE = scerr_pkg::SCERR_SETTLE_CNT
  )
  (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Per-scale fault flags from the measuring front end
    input wire logic [7:0] over_limit,
    input wire logic [7:0] under_limit,
    input wire logic [7:0] over_range,
    input wire logic [7:0] under_range,
    input wire logic [7:0] exc_short,
    input wire logic [7:0] sense_bad,
    input wire logic [7:0] xdcr_bad,
    input wire logic [7:0] conv_done,
    input wire logic [7:0] digit_ovf,
    input wire logic not_normal,
    // Command checker
    input wire logic cmd_valid,
    input wire logic cmd_wrong_state,
    // Outputs to the process
    output logic [7:0] dout_passive,
    output logic [7:0] aout_zero,
    output logic in_process,
    output logic [7:0] weight_invalid,
    output logic disp_err,
    output logic [9:0] disp_code,
    output logic irq
  );
  import scerr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers for the pin-driven fault flags.
  // Every flag is a level, so each bit gets its own two-stage synchroniser;
  // no multi-bit value is carried across, and skew between bits is harmless.
  // The not-normal flag resets high so the block starts out of normal state.

  logic [8:0][7:0] sync1;
  logic [8:0][7:0] sync2;
  logic [1:0] nn_sync;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      nn_sync <= 2'h3;
    end
    else
    begin
      sync1 <= {digit_ovf, conv_done, xdcr_bad, sense_bad, exc_short,
                under_range, over_range, under_limit, over_limit};
      sync2 <= sync1;
      nn_sync <= {nn_sync[0], not_normal};
    end
  end

  wire logic [7:0] s_ovl = sync2[0];
  wire logic [7:0] s_unl = sync2[1];
  wire logic [7:0] s_ovr = sync2[2];
  wire logic [7:0] s_unr = sync2[3];
  wire logic [7:0] s_exc = sync2[4];
  wire logic [7:0] s_sen = sync2[5];
  wire logic [7:0] s_xdc = sync2[6];
  wire logic [7:0] s_cnv = sync2[7];
  wire logic [7:0] s_dig = sync2[8];
  wire logic s_nn = nn_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Registers written by software.

  logic [31:0] ctrl;
  logic [7:0] lim_en;
  logic [SCERR_ST_W-1:0] mask;
  logic [SCERR_ST_W-1:0] status;
  logic [9:0] cmd_code;
  logic [9:0] instr_code;
  logic [7:0][9:0] code;
  logic [7:0][4:0] settle;
  logic [7:0] cnv_q;

  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic rate_wr = wr && paddr == SCERR_OFF_CTRL &&
    pwdata[SCERR_CTRL_RATE +: SCERR_CTRL_RATE_W] !=
    ctrl[SCERR_CTRL_RATE +: SCERR_CTRL_RATE_W];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= SCERR_CTRL_RST;
      lim_en <= SCERR_LIMEN_RST;
      mask <= '0;
    end
    else if (wr)
    begin
      if (paddr == SCERR_OFF_CTRL)
        ctrl <= pwdata;
      if (paddr == SCERR_OFF_LIMEN)
        lim_en <= pwdata[7:0];
      if (paddr == SCERR_OFF_MASK)
        mask <= pwdata[SCERR_ST_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Settling counters: a weight is valid only after enough conversions.
  // The counters are five bits wide, so SETTLE may not exceed 31; a rate
  // change restarts every scale, as all share one rate setting.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settle <= '0;
      cnv_q <= '0;
    end
    else
    begin
      cnv_q <= s_cnv;
      for (int i = 0; i < 8; i++)
      begin
        if (rate_wr)
          settle[i] <= '0;
        else if (s_cnv[i] && !cnv_q[i] && settle[i] < 5'(SETTLE))
          settle[i] <= settle[i] + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Classification: highest priority cause wins; code tracks live cause.
  // Later tests override earlier ones, so the last test is the strongest.

  function automatic logic [9:0] classify(input int i);
    logic [9:0] c;
    c = SCERR_NONE;
    if (s_dig[i])
      c = ctrl[SCERR_CTRL_DIGALT] ? SCERR_DIGITS_ALT : SCERR_DIGITS;
    if (s_unl[i] && lim_en[i])
      c = SCERR_UNDERLOAD;
    if (s_ovl[i] && lim_en[i])
      c = SCERR_OVERLOAD;
    if (s_unr[i])
      c = SCERR_UNDER_RANGE;
    if (s_ovr[i])
      c = SCERR_OVER_RANGE;
    if (settle[i] < 5'(SETTLE))
      c = SCERR_INVALID_IN;
    if (s_xdc[i])
      c = SCERR_TRANSDUCER;
    if (s_sen[i])
      c = SCERR_SENSE;
    if (s_exc[i])
      c = SCERR_EXCITATION;
    if (s_nn)
      c = SCERR_NOT_NORMAL;
    return c;
  endfunction : classify

  // Only weight-group codes are produced per scale; the other groups are
  // raised elsewhere during start-up or set-up.
  logic [7:0] active;
  // Codes reset to not-normal, like the synchroniser, so the outputs stay
  // passive out of reset instead of releasing for one cycle before the
  // first classification lands.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      code <= {8{SCERR_NOT_NORMAL}};
    else
      for (int i = 0; i < 8; i++)
        code[i] <= (i < NSCALE) ? classify(i) : SCERR_NONE;
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      active[i] = code[i] != SCERR_NONE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      instr_code <= SCERR_NOT_NORMAL;
    else
      instr_code <= s_nn ? SCERR_NOT_NORMAL : SCERR_NONE;
  end

  // A rejected command leaves its code until the next accepted command.
  // The command strobe comes from logic on pclk and needs no synchroniser.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_code <= SCERR_NONE;
    else if (cmd_valid)
      cmd_code <= cmd_wrong_state ? SCERR_WRONG_STATE : SCERR_NONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs to the process. All registered.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dout_passive <= 8'hFF;
      aout_zero <= 8'hFF;
      in_process <= 1'b0;
      weight_invalid <= 8'hFF;
    end
    else
    begin
      dout_passive <= active;
      aout_zero <= active;
      in_process <= !(|active) && !s_nn;
      weight_invalid <= active;
    end
  end

  // Display shows the lowest-numbered scale in error; text lookup is
  // done by the display controller from the code.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      disp_err <= 1'b0;
      disp_code <= SCERR_NONE;
    end
    else
    begin
      disp_err <= (|active) || s_nn;
      disp_code <= s_nn ? SCERR_NOT_NORMAL : SCERR_NONE;
      for (int i = 7; i >= 0; i--)
        if (active[i])
          disp_code <= code[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over write-one-to-clear.

  // Edge detector for new errors. It resets to all-in-error, matching the
  // code reset, so leaving reset raises no false event.
  logic [7:0] active_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_q <= 8'hFF;
    else
      active_q <= active;
  end

  logic [SCERR_ST_W-1:0] ev;
  assign ev = {cmd_valid && cmd_wrong_state, active & ~active_q};

  // A write-one-to-clear that meets a new event keeps the bit set, so no
  // event is ever lost to a clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status <= '0;
    else if (wr && paddr == SCERR_OFF_STATUS)
      status <= (status & ~pwdata[SCERR_ST_W-1:0]) | ev;
    else
      status <= status | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // APB read path: zero wait states, reads have no side effects.

  function automatic logic mapped(input logic [11:0] a);
    return a == SCERR_OFF_INSTR || a == SCERR_OFF_CMD ||
      a == SCERR_OFF_CTRL || a == SCERR_OFF_LIMEN ||
      a == SCERR_OFF_STATUS || a == SCERR_OFF_MASK ||
      (a >= SCERR_OFF_SCALE0 && a < SCERR_OFF_SCALE0 + 12'h020 &&
       a[1:0] == 2'h0);
  endfunction : mapped

  // The answer is registered from the setup cycle, so every transfer takes
  // exactly one access cycle and read data stand only in that cycle.
  wire logic setup = psel && !penable;
  logic [31:0] rd;
  logic [11:0] sidx;
  always_comb
  begin
    sidx = paddr - SCERR_OFF_SCALE0;
    rd = 32'h0000_0000;
    unique case (paddr)
      SCERR_OFF_INSTR: rd = {22'h0, instr_code};
      SCERR_OFF_CMD: rd = {22'h0, cmd_code};
      SCERR_OFF_CTRL: rd = ctrl;
      SCERR_OFF_LIMEN: rd = {24'h0, lim_en};
      SCERR_OFF_STATUS: rd = {23'h0, status};
      SCERR_OFF_MASK: rd = {23'h0, mask};
      default:
        if (mapped(paddr))
          rd = {22'h0, code[sidx[4:2]]};
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped(paddr);
      prdata <= (setup && !pwrite) ? rd : 32'h0000_0000;
    end
  end

endmodule : scerr_top

// ===== shared/scerr_pkg.sv
// Constants for the scale error supervisor: register map, codes, fields.
// Assumes an APB master on pclk and a single asynchronous active-low reset.
package scerr_pkg;

  localparam int SCERR_NSCALE = 8;
  localparam int SCERR_CW = 10;

  localparam logic [9:0] SCERR_NONE = 10'h000;
  localparam logic [9:0] SCERR_NOT_NORMAL = 10'h003;
  localparam logic [9:0] SCERR_OVERLOAD = 10'h004;
  localparam logic [9:0] SCERR_OVER_RANGE = 10'h005;
  localparam logic [9:0] SCERR_UNDERLOAD = 10'h006;
  localparam logic [9:0] SCERR_UNDER_RANGE = 10'h007;
  localparam logic [9:0] SCERR_EXCITATION = 10'h00A;
  localparam logic [9:0] SCERR_SENSE = 10'h00B;
  localparam logic [9:0] SCERR_TRANSDUCER = 10'h00C;
  localparam logic [9:0] SCERR_INVALID_IN = 10'h00E;
  localparam logic [9:0] SCERR_DIGITS = 10'h014;
  localparam logic [9:0] SCERR_DIGITS_ALT = 10'h0BF;
  localparam logic [9:0] SCERR_WRONG_STATE = 10'h064;

  localparam logic [11:0] SCERR_OFF_INSTR = 12'h000;
  localparam logic [11:0] SCERR_OFF_CMD = 12'h004;
  localparam logic [11:0] SCERR_OFF_CTRL = 12'h008;
  localparam logic [11:0] SCERR_OFF_LIMEN = 12'h00C;
  localparam logic [11:0] SCERR_OFF_STATUS = 12'h010;
  localparam logic [11:0] SCERR_OFF_MASK = 12'h014;
  localparam logic [11:0] SCERR_OFF_SCALE0 = 12'h020;

  // Control register fields.
  localparam int SCERR_CTRL_DIGALT = 0;
  localparam int SCERR_CTRL_RATE = 1;
  localparam int SCERR_CTRL_RATE_W = 4;
  localparam logic [31:0] SCERR_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] SCERR_LIMEN_RST = 8'h00;

  // Status register: per-scale new-error events, then command error event.
  localparam int SCERR_ST_CMD = 8;
  localparam int SCERR_ST_W = 9;

  // Settling conversions needed before a weight is valid.
  localparam int SCERR_SETTLE_CNT = 16;

endpackage : scerr_pkg

// ===== tb/scerr_monitor.sv
// Checker on the supervisor's top-level ports.
// Assumes a bind onto scerr_top.
module scerr_monitor
  import scerr_pkg::*;
  (
    // Clock and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Faults
    input wire logic not_normal,
    input wire logic [7:0] exc_short,
    input wire logic [7:0] digit_ovf,
    // Outputs
    input wire logic [7:0] dout_passive,
    input wire logic [7:0] aout_zero,
    input wire logic [7:0] weight_invalid,
    input wire logic in_process,
    input wire logic disp_err,
    input wire logic [9:0] disp_code
  );
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("late ready");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad refusal");
  property p_outs;
    aout_zero == dout_passive && weight_invalid == dout_passive;
  endproperty
  a_outs: assert property (p_outs) else $error("outputs split");
  property p_inproc; in_process |-> dout_passive == 8'h00; endproperty
  a_inproc: assert property (p_inproc) else $error("process on");
  property p_disp; disp_err == (disp_code != 10'h000); endproperty
  a_disp: assert property (p_disp) else $error("display code");
  property p_nn; not_normal [*6] |-> !in_process && disp_err; endproperty
  a_nn: assert property (p_nn) else $error("not normal");
  property p_exc; exc_short[0] [*6] |-> dout_passive[0]; endproperty
  a_exc: assert property (p_exc) else $error("short kept");
  property p_ovf; digit_ovf[7] [*6] |-> aout_zero[7]; endproperty
  a_ovf: assert property (p_ovf) else $error("digits kept");
  c_err: cover property (pslverr);
  c_fall: cover property ($fell(in_process));
  c_alt: cover property (disp_code == SCERR_DIGITS_ALT);
endmodule : scerr_monitor

// ===== tb/scerr_host.sv
// Remote control unit: an APB master that reads and writes registers.
// Assumes the bench calls xfer and one clock edge separates calls.
module scerr_host (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : scerr_host

// ===== tb/testbench.sv
// Self-checking bench for the scale error supervisor.
// Assumes the host model drives the register bus.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import scerr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] f [8] = '{default: 8'h00};
  logic [7:0] conv_done = 8'h00;
  logic not_normal = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_wrong_state = 1'b0;
  logic [7:0] dout_passive, aout_zero, weight_invalid;
  logic in_process, disp_err, irq;
  logic [9:0] disp_code;
  int err_count = 0;
  int comparisons = 0;
  // Row k raises fault input k on scale k.
  logic [9:0] tab [8] = '{SCERR_OVERLOAD, SCERR_UNDERLOAD, SCERR_OVER_RANGE,
    SCERR_UNDER_RANGE, SCERR_EXCITATION, SCERR_SENSE, SCERR_TRANSDUCER,
    SCERR_DIGITS};
  ////////////////////////////////////////////////////////////////////////
  initial forever #2 pclk = ~pclk;
  scerr_top #(.SETTLE(2)) i_scerr_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .over_limit(f[0]), .under_limit(f[1]), .over_range(f[2]),
    .under_range(f[3]), .exc_short(f[4]), .sense_bad(f[5]),
    .xdcr_bad(f[6]), .digit_ovf(f[7]), .conv_done(conv_done),
    .not_normal(not_normal), .cmd_valid(cmd_valid),
    .cmd_wrong_state(cmd_wrong_state), .dout_passive(dout_passive),
    .aout_zero(aout_zero), .in_process(in_process),
    .weight_invalid(weight_invalid), .disp_err(disp_err),
    .disp_code(disp_code), .irq(irq));
  scerr_host i_scerr_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  task automatic chk(input string n, input logic [31:0] x, y);
    comparisons++;
    if (y !== x)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, x, y);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_scerr_host.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    i_scerr_host.xfer(1'b0, a, 32'h0, q, e);
    chk("rdata", x, q);
  endtask : rd
  task automatic settle();
    repeat (3)
    begin
      @(posedge pclk) conv_done <= 8'hFF;
      repeat (2) @(posedge pclk);
      conv_done <= 8'h00;
      repeat (2) @(posedge pclk);
    end
    repeat (5) @(posedge pclk);
  endtask : settle
  task automatic summarize();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    #100000;
    err_count++;
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge pclk);
    chk("dout_passive", 8'hFF, dout_passive);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(SCERR_OFF_SCALE0, 14);
    settle();
    rd(SCERR_OFF_INSTR, 0);
    chk("in_process", 1, in_process);
    wr(SCERR_OFF_LIMEN, 32'hFF);
    wr(SCERR_OFF_MASK, 32'h1FF);
    for (int k = 0; k < 8; k++)
    begin
      f[k][k] <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(SCERR_OFF_SCALE0 + 12'(4 * k), tab[k]);
      chk("dout_passive", 8'h01 << k, dout_passive);
      chk("in_process", 0, in_process);
      chk("irq", 1, irq);
      f[k][k] <= 1'b0;
      repeat (6) @(posedge pclk);
      rd(SCERR_OFF_SCALE0 + 12'(4 * k), 0);
      wr(SCERR_OFF_STATUS, 32'h1FF);
    end
    wr(SCERR_OFF_MASK, 32'h100);
    wr(SCERR_OFF_CTRL, 32'h1);
    f[4][0] <= 1'b1;
    f[2][0] <= 1'b1;
    f[7][1] <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(SCERR_OFF_SCALE0, SCERR_EXCITATION);
    rd(SCERR_OFF_SCALE0 + 12'h004, SCERR_DIGITS_ALT);
    chk("disp_code", SCERR_EXCITATION, disp_code);
    chk("irq", 0, irq);
    f[4][0] <= 1'b0;
    f[2][0] <= 1'b0;
    f[7][1] <= 1'b0;
    wr(SCERR_OFF_CTRL, 32'h2);
    repeat (6) @(posedge pclk);
    rd(SCERR_OFF_SCALE0, 14);
    settle();
    not_normal <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(SCERR_OFF_INSTR, 3);
    chk("weight_invalid", 8'hFF, weight_invalid);
    not_normal <= 1'b0;
    repeat (6) @(posedge pclk);
    wr(SCERR_OFF_STATUS, 32'h1FF);
    cmd_valid <= 1'b1;
    cmd_wrong_state <= 1'b1;
    @(posedge pclk) cmd_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(SCERR_OFF_CMD, SCERR_WRONG_STATE);
    rd(SCERR_OFF_CMD, SCERR_WRONG_STATE);
    rd(SCERR_OFF_STATUS, 32'h100);
    chk("irq", 1, irq);
    i_scerr_host.xfer(1'b0, 12'hFFC, 32'h0, q, e);
    chk("pslverr", 1, e);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("dout_passive", 8'hFF, dout_passive);
    chk("in_process", 0, in_process);
    chk("irq", 0, irq);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(SCERR_OFF_CMD, 0);
    rd(SCERR_OFF_SCALE0, 14);
    summarize();
  end
endmodule : testbench
bind scerr_top scerr_monitor i_scerr_monitor (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .not_normal(not_normal),
  .exc_short(exc_short), .digit_ovf(digit_ovf),
  .dout_passive(dout_passive), .aout_zero(aout_zero),
  .weight_invalid(weight_invalid), .in_process(in_process),
  .disp_err(disp_err), .disp_code(disp_code));
